//--- pkg/insn_decode_pkg.sv
// opcode, flag-class and clock-count constants for the s..x instruction decoder
// assumes a fetch stage that presents opcode bytes and modrm already aligned
//
// Contract
// (RULE1) opcode 9B waits until coprocessor not busy, charges 5 clocks both modes
// (RULE2) 0F 09 is cache write-back-invalidate, 4 clocks both modes
// (RULE3) 0F 00 reg 100 read verify, protected only, zero flag only, 9/10 hit, 12 miss
// (RULE4) 0F 00 reg 101 write verify, protected only, zero flag only, same timing
// (RULE5) 0F C0/C1 exchange-and-add updates six flags; 3 clocks register, 6 memory
// (RULE6) exclusive OR clears OF and CF, updates SF ZF PF; register form 1 clock
// (RULE7) A8/A9 test immediate with accumulator, 1 clock, flags only
// (RULE8) F6/F7 reg 000 test immediate with reg/mem, 1/3 hit, 5 miss
// (RULE9) 2C/2D subtract immediate from accumulator, 1 clock both modes
// (RULE10) separate counts for register/hit and miss, per mode, every form; code counts ignore mode, and 0F C0/C1, 86/87, AA/AB have no miss count
// (RULE11) protected-only instruction in real mode raises invalid opcode, vector 6
// (RULE12) verify with privilege violation clears zero flag, no protection fault
// (RULE13) exchange with memory operand asserts bus lock regardless of prefix
// (RULE14) two-value counts: first for register operand, second for cache hit
package insn_decode_pkg;
	localparam logic [7:0] OP_TWO_BYTE = 8'h0F;
	localparam logic [7:0] OP_WAIT = 8'h9B;
	localparam logic [7:0] OP_CACHE_WRITEBACK_INVALIDATE_2 = 8'h09;
	localparam logic [7:0] OP_GRP6_2 = 8'h00;
	localparam logic [6:0] OP_EXCHANGE_AND_ADD_2 = 7'h60;
	localparam logic [6:0] OP_STORE_STR = 7'h55;
	localparam logic [6:0] OP_TEST_ACC = 7'h54;
	localparam logic [6:0] OP_TEST_IMM = 7'h7B;
	localparam logic [6:0] OP_SUB_ACC = 7'h16;
	localparam logic [5:0] OP_SUB_RM = 6'h0A;
	localparam logic [6:0] OP_TEST_RM = 7'h42;
	localparam logic [6:0] OP_EXCHANGE_OPERANDS_RM = 7'h43;
	localparam logic [4:0] OP_EXCHANGE_OPERANDS_ACC = 5'h12;
	localparam logic [7:0] OP_TABLE_TRANSLATE_BYTE = 8'hD7;
	localparam logic [5:0] OP_XOR_RM = 6'h0C;
	localparam logic [6:0] OP_XOR_ACC = 7'h1A;
	localparam logic [5:0] OP_IMM_GRP = 6'h20;
	localparam logic [2:0] REG_SUB = 3'h5;
	localparam logic [2:0] REG_XOR = 3'h6;
	localparam logic [2:0] REG_TEST = 3'h0;
	localparam logic [2:0] REG_VERIFY_READ_ACCESS = 3'h4;
	localparam logic [2:0] REG_VERIFY_WRITE_ACCESS = 3'h5;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [7:0] VEC_INVALID_OP = 8'h06;
	// clock counts
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_5 = 4'h5;
	localparam logic [3:0] CYC_6 = 4'h6;
	localparam logic [3:0] CYC_9 = 4'h9;
	localparam logic [3:0] CYC_10 = 4'hA;
	localparam logic [3:0] CYC_12 = 4'hC;
	// flag bit positions in the 6-bit arithmetic flag vector
	localparam int FL_CF = 0;
	localparam int FL_PF = 1;
	localparam int FL_AF = 2;
	localparam int FL_ZF = 3;
	localparam int FL_SF = 4;
	localparam int FL_OF = 5;
	localparam logic [5:0] FLAGS_ALL = 6'h3F;
	localparam logic [5:0] FLAGS_LOGIC = 6'h3B;
	localparam logic [5:0] FLAGS_ZERO = 6'h08;
	localparam logic [5:0] FLAGS_NONE = 6'h00;
	localparam logic [5:0] FLAGS_LOGIC_CLR = 6'h21;

	typedef enum logic [3:0] {
		CLS_NONE, CLS_STORE_STR, CLS_SUB, CLS_TEST, CLS_VERIFY_READ_ACCESS, CLS_VERIFY_WRITE_ACCESS, CLS_WAIT,
		CLS_CACHE_WRITEBACK_INVALIDATE, CLS_EXCHANGE_AND_ADD, CLS_EXCHANGE_OPERANDS, CLS_TABLE_TRANSLATE_BYTE, CLS_XOR, CLS_INVALID
	} insn_class_e;
endpackage : insn_decode_pkg

//--- src/insn_decode_s_to_x.sv
// decoder and cycle sequencer for store-string through exclusive OR
// assumes operand bytes stable while insn_valid_i is high until done_o
`timescale 1ns/10ps
`default_nettype none
module insn_decode_s_to_x
	import insn_decode_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic insn_valid_i,
	input wire logic [7:0] opcode0_i,
	input wire logic [7:0] opcode1_i,
	input wire logic [7:0] modrm_i,
	input wire logic protected_mode_i,
	input wire logic cache_miss_i,
	input wire logic coproc_busy_n_i,
	input wire logic selector_priv_ok_i,
	output logic busy_o,
	output logic done_o,
	output logic [3:0] insn_class_o,
	output logic [3:0] cycles_o,
	output logic [5:0] flags_update_o,
	output logic [5:0] flags_clear_o,
	output logic result_write_o,
	output logic zero_flag_clear_o,
	output logic exception_o,
	output logic [7:0] exception_vector_o,
	output logic bus_lock_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT_COPROC} seq_state_e;

	// ----------------------------------------
	// combinational decode
	// ----------------------------------------
	insn_class_e cls_next;
	logic [3:0] cyc_next;
	logic [5:0] upd_next;
	logic [5:0] clr_next;
	logic wr_next;
	logic lock_next;
	logic mem_op;
	logic [2:0] reg_f;

	assign reg_f = modrm_i[5:3];
	assign mem_op = modrm_i[7:6] != MOD_REG;

	always_comb begin
		cls_next = CLS_INVALID;
		cyc_next = CYC_1;
		upd_next = FLAGS_NONE;
		clr_next = FLAGS_NONE;
		wr_next = 1'b0;
		lock_next = 1'b0;
		if (opcode0_i == OP_TWO_BYTE) begin
			if (opcode1_i == OP_CACHE_WRITEBACK_INVALIDATE_2) begin
				cls_next = CLS_CACHE_WRITEBACK_INVALIDATE;
				cyc_next = CYC_4; // RULE2
			end else if (opcode1_i[7:1] == OP_EXCHANGE_AND_ADD_2) begin
				cls_next = CLS_EXCHANGE_AND_ADD;
				upd_next = FLAGS_ALL; // RULE5
				wr_next = 1'b1;
				cyc_next = mem_op ? CYC_6 : CYC_3; // RULE5
			end else if (opcode1_i == OP_GRP6_2 && (reg_f == REG_VERIFY_READ_ACCESS || reg_f == REG_VERIFY_WRITE_ACCESS)) begin
				cls_next = (reg_f == REG_VERIFY_READ_ACCESS) ? CLS_VERIFY_READ_ACCESS : CLS_VERIFY_WRITE_ACCESS; // RULE3 RULE4
				upd_next = FLAGS_ZERO;
				// first count register, second cache hit, else miss
				cyc_next = !mem_op ? CYC_9 : (cache_miss_i ? CYC_12 : CYC_10); // RULE14 RULE10
			end
		end else if (opcode0_i == OP_WAIT) begin
			cls_next = CLS_WAIT;
			cyc_next = CYC_5; // RULE1
		end else if (opcode0_i[7:1] == OP_STORE_STR) begin
			cls_next = CLS_STORE_STR;
			wr_next = 1'b1;
			cyc_next = CYC_3;
		end else if (opcode0_i[7:1] == OP_SUB_ACC) begin
			cls_next = CLS_SUB;
			upd_next = FLAGS_ALL;
			wr_next = 1'b1;
			cyc_next = CYC_1; // RULE9
		end else if (opcode0_i[7:2] == OP_SUB_RM) begin
			cls_next = CLS_SUB;
			upd_next = FLAGS_ALL;
			wr_next = 1'b1;
			cyc_next = !mem_op ? CYC_1 : (cache_miss_i ? CYC_5 : CYC_3); // RULE10
		end else if (opcode0_i[7:1] == OP_XOR_ACC || opcode0_i[7:2] == OP_XOR_RM) begin
			cls_next = CLS_XOR;
			upd_next = FLAGS_LOGIC; // RULE6
			clr_next = FLAGS_LOGIC_CLR; // RULE6
			wr_next = 1'b1;
			cyc_next = (!mem_op || opcode0_i[7:1] == OP_XOR_ACC) ? CYC_1 :
				(cache_miss_i ? CYC_5 : CYC_3); // RULE6 RULE10
		end else if (opcode0_i[7:1] == OP_TEST_ACC) begin
			cls_next = CLS_TEST;
			upd_next = FLAGS_LOGIC;
			clr_next = FLAGS_LOGIC_CLR;
			cyc_next = CYC_1; // RULE7
		end else if ((opcode0_i[7:1] == OP_TEST_IMM && reg_f == REG_TEST) || opcode0_i[7:1] == OP_TEST_RM) begin
			cls_next = CLS_TEST;
			upd_next = FLAGS_LOGIC;
			clr_next = FLAGS_LOGIC_CLR;
			cyc_next = !mem_op ? CYC_1 : (cache_miss_i ? CYC_5 : CYC_3); // RULE8 RULE14
		end else if (opcode0_i[7:2] == OP_IMM_GRP && (reg_f == REG_SUB || reg_f == REG_XOR)) begin
			cls_next = (reg_f == REG_SUB) ? CLS_SUB : CLS_XOR;
			upd_next = (reg_f == REG_SUB) ? FLAGS_ALL : FLAGS_LOGIC;
			clr_next = (reg_f == REG_SUB) ? FLAGS_NONE : FLAGS_LOGIC_CLR;
			wr_next = 1'b1;
			cyc_next = !mem_op ? CYC_1 : (cache_miss_i ? CYC_5 : CYC_3); // RULE14
		end else if (opcode0_i[7:1] == OP_EXCHANGE_OPERANDS_RM) begin
			cls_next = CLS_EXCHANGE_OPERANDS;
			wr_next = 1'b1;
			lock_next = mem_op; // RULE13
			cyc_next = mem_op ? CYC_4 : CYC_3; // RULE14
		end else if (opcode0_i[7:3] == OP_EXCHANGE_OPERANDS_ACC) begin
			cls_next = CLS_EXCHANGE_OPERANDS;
			wr_next = 1'b1;
			cyc_next = CYC_3;
		end else if (opcode0_i == OP_TABLE_TRANSLATE_BYTE) begin
			cls_next = CLS_TABLE_TRANSLATE_BYTE;
			wr_next = 1'b1;
			cyc_next = cache_miss_i ? CYC_5 : CYC_3;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	seq_state_e state_reg;
	logic [3:0] count_reg;
	logic take;
	logic prot_only_fault;

	assign take = state_reg == ST_IDLE && insn_valid_i;
	assign prot_only_fault = (cls_next == CLS_VERIFY_READ_ACCESS || cls_next == CLS_VERIFY_WRITE_ACCESS) && !protected_mode_i;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take && cls_next != CLS_INVALID && !prot_only_fault) begin
						state_reg <= (cls_next == CLS_WAIT) ? ST_WAIT_COPROC : ST_EXEC;
					end
				end
				ST_WAIT_COPROC: begin
					if (coproc_busy_n_i) begin // RULE1
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (count_reg == 4'h0) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// remaining-cycle counter
	// ----------------------------------------
	// release cycle out of the stall is the first charged clock
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			count_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take && cls_next != CLS_INVALID && !prot_only_fault) begin
						count_reg <= cyc_next - 4'h1;
					end
				end
				ST_WAIT_COPROC: begin
					if (coproc_busy_n_i) begin
						count_reg <= count_reg - 4'h1; // RULE1
					end
				end
				ST_EXEC: begin
					if (count_reg != 4'h0) begin
						count_reg <= count_reg - 4'h1;
					end
				end
				default: count_reg <= 4'h0;
			endcase
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic finish;
	assign finish = state_reg == ST_EXEC && count_reg == 4'h0;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			insn_class_o <= 4'h0;
			cycles_o <= 4'h0;
			flags_update_o <= FLAGS_NONE;
			flags_clear_o <= FLAGS_NONE;
			result_write_o <= 1'b0;
			zero_flag_clear_o <= 1'b0;
			bus_lock_o <= 1'b0;
		end else if (take) begin
			insn_class_o <= 4'(cls_next);
			cycles_o <= cyc_next; // RULE10
			flags_update_o <= upd_next;
			flags_clear_o <= clr_next;
			result_write_o <= wr_next; // RULE7
			zero_flag_clear_o <= (cls_next == CLS_VERIFY_READ_ACCESS || cls_next == CLS_VERIFY_WRITE_ACCESS) && !selector_priv_ok_i; // RULE12
			bus_lock_o <= lock_next && !prot_only_fault && cls_next != CLS_INVALID; // RULE13
		end else if (finish) begin
			bus_lock_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			exception_o <= 1'b0;
			exception_vector_o <= 8'h00;
		end else begin
			busy_o <= (take && cls_next != CLS_INVALID && !prot_only_fault) || (state_reg != ST_IDLE && !finish);
			done_o <= finish;
			exception_o <= take && (cls_next == CLS_INVALID || prot_only_fault); // RULE11
			exception_vector_o <= (take && prot_only_fault) ? VEC_INVALID_OP : 8'h00; // RULE11
		end
	end
endmodule : insn_decode_s_to_x
`default_nettype wire

//--- sim/insn_decode_s_to_x_assertions.sv
// concurrent checks on the s..x decoder ports
// assumes binding to insn_decode_s_to_x, one clock domain
`timescale 1ns/10ps
`default_nettype none
module insn_decode_s_to_x_checker
	import insn_decode_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic insn_valid_i,
	input wire logic [7:0] opcode0_i,
	input wire logic [7:0] opcode1_i,
	input wire logic [7:0] modrm_i,
	input wire logic protected_mode_i,
	input wire logic coproc_busy_n_i,
	input wire logic selector_priv_ok_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic [3:0] cycles_o,
	input wire logic [5:0] flags_update_o,
	input wire logic [5:0] flags_clear_o,
	input wire logic result_write_o,
	input wire logic zero_flag_clear_o,
	input wire logic exception_o,
	input wire logic [7:0] exception_vector_o,
	input wire logic bus_lock_o
);
	// ----
	// properties
	// ----
	logic take;
	assign take = insn_valid_i && !busy_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_one; busy_o ##1 done_o; endsequence
	sequence s_pfx; take && opcode0_i == OP_TWO_BYTE; endsequence
	sequence s_verify; s_pfx ##0 opcode1_i == OP_GRP6_2 && modrm_i[5:4] == 2'b10; endsequence
	property p_sub; take && opcode0_i[7:1] == OP_SUB_ACC |-> ##1 s_one ##0 cycles_o == CYC_1; endproperty
	property p_test; take && opcode0_i[7:1] == OP_TEST_ACC |-> ##1 !result_write_o ##0 s_one; endproperty
	property p_xor; take && opcode0_i[7:2] == OP_XOR_RM && modrm_i[7:6] == MOD_REG
		|-> ##1 flags_clear_o == FLAGS_LOGIC_CLR && flags_update_o == FLAGS_LOGIC ##0 s_one; endproperty
	property p_cache_writeback_invalidate; s_pfx ##0 opcode1_i == OP_CACHE_WRITEBACK_INVALIDATE_2 |-> ##1 (busy_o && !done_o)[*4] ##1 done_o; endproperty
	property p_exchange_and_add; s_pfx ##0 opcode1_i[7:1] == OP_EXCHANGE_AND_ADD_2 && modrm_i[7:6] == MOD_REG
		|-> ##1 (busy_o && flags_update_o == FLAGS_ALL)[*3] ##1 done_o; endproperty
	property p_wait; take && opcode0_i == OP_WAIT && coproc_busy_n_i ##1 coproc_busy_n_i[*5]
		|-> ##1 done_o && cycles_o == CYC_5; endproperty
	property p_lock; take && opcode0_i[7:1] == OP_EXCHANGE_OPERANDS_RM && modrm_i[7:6] != MOD_REG |-> ##1 bus_lock_o[*4]; endproperty
	property p_real; s_verify ##0 !protected_mode_i
		|-> ##1 exception_o && exception_vector_o == VEC_INVALID_OP && !busy_o; endproperty
	property p_deny; s_verify ##0 protected_mode_i && !selector_priv_ok_i
		|-> ##1 zero_flag_clear_o && !exception_o; endproperty
	a_sub: assert property (p_sub) else $error("short subtract timing wrong");
	a_test: assert property (p_test) else $error("accumulator test wrong");
	a_xor: assert property (p_xor) else $error("exclusive or flags wrong");
	a_cache_writeback_invalidate: assert property (p_cache_writeback_invalidate) else $error("writeback invalidate timing wrong");
	a_exchange_and_add: assert property (p_exchange_and_add) else $error("exchange add wrong");
	a_wait: assert property (p_wait) else $error("coprocessor wait timing wrong");
	a_lock: assert property (p_lock) else $error("bus lock missing");
	a_real: assert property (p_real) else $error("real mode verify not refused");
	a_deny: assert property (p_deny) else $error("privilege fail not flagged");
endmodule : insn_decode_s_to_x_checker
bind insn_decode_s_to_x insn_decode_s_to_x_checker u_chk (.core_clk_i, .rst_n_i, .insn_valid_i, .opcode0_i,
	.opcode1_i, .modrm_i, .protected_mode_i, .coproc_busy_n_i, .selector_priv_ok_i, .busy_o, .done_o, .cycles_o,
	.flags_update_o, .flags_clear_o, .result_write_o, .zero_flag_clear_o, .exception_o, .exception_vector_o,
	.bus_lock_o);
`default_nettype wire

//--- sim/insn_decode_s_to_x_tb.sv
// self-checking bench for the s..x decoder
// assumes the package and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module insn_decode_s_to_x_tb;
	import insn_decode_pkg::*;
	logic core_clk_i, rst_n_i, insn_valid_i, protected_mode_i, cache_miss_i, coproc_busy_n_i, selector_priv_ok_i;
	logic [7:0] opcode0_i, opcode1_i, modrm_i, exception_vector_o, n;
	logic busy_o, done_o, result_write_o, zero_flag_clear_o, exception_o, bus_lock_o, lock_seen;
	logic [3:0] insn_class_o, cycles_o;
	logic [5:0] flags_update_o, flags_clear_o;
	int err_total, checked;
	insn_decode_s_to_x u_dut (.core_clk_i, .rst_n_i, .insn_valid_i, .opcode0_i, .opcode1_i, .modrm_i,
		.protected_mode_i, .cache_miss_i, .coproc_busy_n_i, .selector_priv_ok_i, .busy_o, .done_o, .insn_class_o,
		.cycles_o, .flags_update_o, .flags_clear_o, .result_write_o, .zero_flag_clear_o, .exception_o,
		.exception_vector_o, .bus_lock_o);
	// ----
	// shared tasks
	// ----
	task automatic give_verdict;
		if (err_total == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic run(input logic [7:0] a, b, m, input logic pm, miss, ok);
		@(negedge core_clk_i);
		{opcode0_i, opcode1_i, modrm_i, protected_mode_i, cache_miss_i, selector_priv_ok_i, insn_valid_i} = {a, b, m, pm, miss, ok, 1'b1};
		@(negedge core_clk_i);
		insn_valid_i = 1'b0;
		lock_seen = bus_lock_o;
		n = 8'h00;
		while (done_o !== 1'b1 && exception_o !== 1'b1 && n < 8'h30) begin
			@(negedge core_clk_i);
			n++;
		end
		if (n == 8'h30) begin
			err_total++;
			give_verdict();
		end
	endtask : run
	task automatic exp3(input logic [7:0] c, input logic [3:0] k);
		chk(n, c);
		chk({4'h0, cycles_o}, c);
		chk({4'h0, insn_class_o}, {4'h0, k});
	endtask : exp3
	// ----
	// scenarios
	// ----
	task automatic t_sub_cache_writeback_invalidate;
		for (int p = 0; p < 2; p++) begin
			run(8'h2C, 8'h00, 8'h00, p[0], 1'b0, 1'b1);
			exp3(8'h01, CLS_SUB);
			run(8'h0F, 8'h09, 8'h00, p[0], 1'b0, 1'b1);
			exp3(8'h04, CLS_CACHE_WRITEBACK_INVALIDATE);
		end
	endtask : t_sub_cache_writeback_invalidate
	task automatic t_test_xor;
		run(8'hA8, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
		exp3(8'h01, CLS_TEST);
		chk({7'h00, result_write_o}, 8'h00);
		run(8'hF6, 8'h00, 8'hC0, 1'b1, 1'b0, 1'b1);
		exp3(8'h01, CLS_TEST);
		run(8'hF7, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
		exp3(8'h03, CLS_TEST);
		run(8'hF7, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1);
		exp3(8'h05, CLS_TEST);
		run(8'h32, 8'h00, 8'hC1, 1'b0, 1'b0, 1'b1);
		exp3(8'h01, CLS_XOR);
		chk({2'h0, flags_update_o}, 8'h3B);
		chk({2'h0, flags_clear_o}, 8'h21);
	endtask : t_test_xor
	task automatic t_verify;
		run(8'h0F, 8'h00, 8'hE0, 1'b1, 1'b0, 1'b1);
		exp3(8'h09, CLS_VERIFY_READ_ACCESS);
		run(8'h0F, 8'h00, 8'h20, 1'b1, 1'b0, 1'b1);
		exp3(8'h0A, CLS_VERIFY_READ_ACCESS);
		run(8'h0F, 8'h00, 8'h20, 1'b1, 1'b1, 1'b1);
		exp3(8'h0C, CLS_VERIFY_READ_ACCESS);
		run(8'h0F, 8'h00, 8'h28, 1'b1, 1'b0, 1'b1);
		exp3(8'h0A, CLS_VERIFY_WRITE_ACCESS);
		chk({2'h0, flags_update_o}, 8'h08);
		run(8'h0F, 8'h00, 8'hE8, 1'b1, 1'b0, 1'b0);
		chk({7'h00, zero_flag_clear_o}, 8'h01);
		run(8'h0F, 8'h00, 8'hE0, 1'b0, 1'b0, 1'b1);
		chk({7'h00, exception_o}, 8'h01);
		chk(exception_vector_o, 8'h06);
	endtask : t_verify
	task automatic t_wait;
		run(8'h9B, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
		exp3(8'h05, CLS_WAIT);
		coproc_busy_n_i = 1'b0;
		fork
			run(8'h9B, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
			begin
				repeat (12) @(negedge core_clk_i);
				coproc_busy_n_i = 1'b1;
			end
		join
		chk(n, 8'h0F);
	endtask : t_wait
	task automatic t_exchange_and_add_exchange_operands;
		run(8'h0F, 8'hC1, 8'hC8, 1'b0, 1'b0, 1'b1);
		exp3(8'h03, CLS_EXCHANGE_AND_ADD);
		chk({2'h0, flags_update_o}, 8'h3F);
		run(8'h0F, 8'hC0, 8'h08, 1'b1, 1'b1, 1'b1);
		exp3(8'h06, CLS_EXCHANGE_AND_ADD);
		run(8'h87, 8'h00, 8'h08, 1'b0, 1'b1, 1'b1);
		exp3(8'h04, CLS_EXCHANGE_OPERANDS);
		chk({7'h00, lock_seen}, 8'h01);
		run(8'h87, 8'h00, 8'hC8, 1'b1, 1'b0, 1'b1);
		exp3(8'h03, CLS_EXCHANGE_OPERANDS);
		chk({7'h00, lock_seen}, 8'h00);
		run(8'h91, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1);
		exp3(8'h03, CLS_EXCHANGE_OPERANDS);
		run(8'hD7, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
		exp3(8'h05, CLS_TABLE_TRANSLATE_BYTE);
		run(8'hAA, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1);
		exp3(8'h03, CLS_STORE_STR);
		run(8'h81, 8'h00, 8'h28, 1'b1, 1'b0, 1'b1);
		exp3(8'h03, CLS_SUB);
		run(8'h83, 8'h00, 8'hF0, 1'b0, 1'b0, 1'b1);
		exp3(8'h01, CLS_XOR);
		chk({2'h0, flags_clear_o}, 8'h21);
	endtask : t_exchange_and_add_exchange_operands
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	initial begin
		{rst_n_i, insn_valid_i, protected_mode_i, cache_miss_i, selector_priv_ok_i} = 5'h00;
		{opcode0_i, opcode1_i, modrm_i} = 24'h00_0000;
		coproc_busy_n_i = 1'b1;
		repeat (5) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		t_sub_cache_writeback_invalidate();
		t_test_xor();
		t_verify();
		t_wait();
		t_exchange_and_add_exchange_operands();
		give_verdict();
	end
endmodule : insn_decode_s_to_x_tb
`default_nettype wire
